// ---- rtl/exec_pkg.sv ----
// Shared constants and types for the instruction execute block.
// Assumes one 50 MHz clock and an APB master with 32-bit data.
package exec_pkg;

   // ---------------------------------------------------------------
   // Types
   // ---------------------------------------------------------------
   typedef logic [13:0] instr_t;
   typedef logic [12:0] pc_t;
   typedef logic [11:0] apb_addr_t;
   typedef logic [31:0] word_t;

   typedef enum logic [1:0] {
      ST_EXEC  = 2'h1,
      ST_FLUSH = 2'h2
   } exec_st_t;

   // ---------------------------------------------------------------
   // Register offsets (byte addresses)
   // ---------------------------------------------------------------
   localparam apb_addr_t OFS_CTRL  = 12'h000;
   localparam apb_addr_t OFS_WREG  = 12'h004;
   localparam apb_addr_t OFS_LATCH = 12'h008;
   localparam apb_addr_t OFS_STAT  = 12'h00C;
   localparam apb_addr_t OFS_PC    = 12'h010;
   localparam apb_addr_t OFS_FILE  = 12'h040;

   // ---------------------------------------------------------------
   // Field positions and reset values
   // ---------------------------------------------------------------
   localparam int CTRL_RUN_BIT   = 0;
   localparam int STAT_Z_BIT     = 0;
   localparam int STAT_FLUSH_BIT = 1;
   localparam int STAT_Q_LSB     = 4;
   localparam int IR_DEST_BIT    = 7;
   localparam int LATCH_HI       = 4;
   localparam int LATCH_LO       = 3;
   localparam logic       CTRL_RST  = 1'h0;
   localparam pc_t        PC_RST    = 13'h0000;
   localparam logic [7:0] W_RST     = 8'h00;
   localparam logic [4:0] LATCH_RST = 5'h00;

   // ---------------------------------------------------------------
   // Instruction classes, opcodes, Q phases
   // ---------------------------------------------------------------
   localparam logic [1:0] CLS_FILE = 2'h0;
   localparam logic [1:0] CLS_BR   = 2'h2;
   localparam logic [1:0] CLS_LIT  = 2'h3;
   localparam logic [3:0] OP_COMP  = 4'h9;
   localparam logic [3:0] OP_DEC   = 4'h3;
   localparam logic [3:0] OP_INC   = 4'hA;
   localparam logic [3:0] OP_INCSZ = 4'hF;
   localparam logic [3:0] OP_ORLIT = 4'h8;
   localparam logic [1:0] Q_DEC    = 2'h0;
   localparam logic [1:0] Q_RD     = 2'h1;
   localparam logic [1:0] Q_PROC   = 2'h2;
   localparam logic [1:0] Q_WR     = 2'h3;

endpackage

// ---- rtl/alu_if.sv ----
// Carrier between the sequencer and the decode/compute unit.
// Assumes both ends sit in the same clock domain.
`timescale 1ns/100ps
interface alu_if;
   import exec_pkg::*;
   instr_t     ir;
   logic [7:0] opnd;
   logic [7:0] w;
   logic [7:0] res;
   logic       we_w;
   logic       we_f;
   logic       upd_z;
   logic       is_br;
   logic       is_skz;
   modport core (output ir, opnd, w, input res, we_w, we_f, upd_z, is_br, is_skz);
   modport alu  (input ir, opnd, w, output res, we_w, we_f, upd_z, is_br, is_skz);
endinterface // alu_if

// ---- rtl/exec_alu.sv ----
// Combinational decode and compute for the supported opcodes.
// Assumes the sequencer holds ir, opnd and w stable through Q3.
`timescale 1ns/100ps
module exec_alu (
   alu_if.alu a   // Decode/compute side
);
   import exec_pkg::*;

   always_comb begin
      a.res    = a.opnd;
      a.we_w   = 1'b0;
      a.we_f   = 1'b0;
      a.upd_z  = 1'b0;
      a.is_br  = 1'b0;
      a.is_skz = 1'b0;
      case (a.ir[13:12])
         CLS_FILE: begin
            a.we_w  = !a.ir[IR_DEST_BIT];
            a.we_f  = a.ir[IR_DEST_BIT];
            a.upd_z = 1'b1;
            case (a.ir[11:8])
               OP_COMP:  a.res = ~a.opnd;
               OP_DEC:   a.res = a.opnd - 8'h01;
               OP_INC:   a.res = a.opnd + 8'h01;
               OP_INCSZ: begin
                  a.res    = a.opnd + 8'h01;
                  a.upd_z  = 1'b0;
                  a.is_skz = 1'b1;
               end
               default: begin
                  // Unsupported file ops retire as no-operation
                  a.we_w  = 1'b0;
                  a.we_f  = 1'b0;
                  a.upd_z = 1'b0;
               end
            endcase
         end
         CLS_BR:  a.is_br = a.ir[11];
         CLS_LIT: begin
            if (a.ir[11:8] == OP_ORLIT) begin
               a.res   = a.w | a.ir[7:0];
               a.we_w  = 1'b1;
               a.upd_z = 1'b1;
            end
         end
         default: ;
      endcase
   end

endmodule // exec_alu

// ---- rtl/exec_core.sv ----
// Instruction execute block: Q-phase sequencer, W, zero flag, file
// registers, program counter and APB register slave.
// Assumes program memory answers PM_ADDR with PM_DATA by Q1.
//
// Function
// - File ops: destination bit 0 writes W, 1 writes the file register.
// - Complement inverts the file register, routes by destination, updates Z.
// - Decrement subtracts one, routes by destination, updates Z.
// - Branch loads PC[10:0] from literal, PC[12:11] from latch bits 4:3.
// - Branch takes two cycles; second cycle does nothing in any phase.
// - Branch first cycle: decode Q1, read Q2, process Q3, write PC Q4.
// - Increment adds one with wrap to zero, routes by destination, updates Z.
// - Increment-skip stores result; zero result flushes next instruction.
// - OR-literal ORs the 8-bit literal into W and updates Z.
// - Single-cycle ops: decode Q1, read Q2, process Q3, write Q4.
`timescale 1ns/100ps
module exec_core #(
   parameter int FILE_DEPTH = 16
) (
   input  wire logic               REF_CLK,   // 50 MHz clock
   input  wire logic               RESET_N,   // Sync reset, active low
   input  wire logic               PSEL,      // APB select
   input  wire logic               PENABLE,   // APB access phase
   input  wire logic               PWRITE,    // APB write
   input  wire exec_pkg::apb_addr_t PADDR,    // APB byte address
   input  wire exec_pkg::word_t    PWDATA,    // APB write data
   output exec_pkg::word_t         PRDATA,    // APB read data
   output logic                    PREADY,    // APB ready
   output logic                    PSLVERR,   // APB error
   output exec_pkg::pc_t           PM_ADDR,   // Program memory address
   input  wire exec_pkg::instr_t   PM_DATA    // Program memory word
);
   import exec_pkg::*;

   // ---------------------------------------------------------------
   // Parameter check
   // ---------------------------------------------------------------
   localparam int AW = $clog2(FILE_DEPTH);

   if (FILE_DEPTH < 2 || FILE_DEPTH > 128 ||
       (FILE_DEPTH & (FILE_DEPTH - 1)) != 0) begin : g_bad_depth
      $error("FILE_DEPTH must be a power of two from 2 to 128");
   end

   // ---------------------------------------------------------------
   // State
   // ---------------------------------------------------------------
   typedef struct packed {
      exec_st_t                    st;
      logic [1:0]                  q;
      logic                        run;
      pc_t                         pc;
      logic [4:0]                  latch;
      logic [7:0]                  w;
      logic                        z;
      logic                        skip_inc;
      instr_t                      ir;
      logic [7:0]                  opnd;
      logic [7:0]                  res;
      logic [FILE_DEPTH-1:0][7:0]  files;
      word_t                       prdata;
      logic                        pready;
      logic                        pslverr;
   } state_t;

   localparam state_t RST = '{st: ST_EXEC, q: Q_DEC, run: CTRL_RST, pc: PC_RST,
                              latch: LATCH_RST, w: W_RST, default: '0};

   state_t s;
   state_t n;
   logic   cyc_go;
   logic   core_we_w;
   logic   core_we_f;
   logic   pc_load_br;
   logic   setup;
   logic   wr_acc;
   word_t  rd;

   alu_if a ();

   exec_alu u_alu (
      .a (a.alu)
   );

   assign a.ir   = s.ir;
   assign a.opnd = s.opnd;
   assign a.w    = s.w;

   // ---------------------------------------------------------------
   // Decode helpers
   // ---------------------------------------------------------------
   function automatic logic [AW-1:0] fidx(input instr_t ir);
      return ir[AW-1:0];
   endfunction

   function automatic logic file_hit(input apb_addr_t ad);
      return ad >= OFS_FILE && ad < OFS_FILE + 12'(4 * FILE_DEPTH)
             && ad[1:0] == 2'h0;
   endfunction

   function automatic logic [AW-1:0] apb_idx(input apb_addr_t ad);
      return ad[AW+1:2];
   endfunction

   // ---------------------------------------------------------------
   // Next state
   // ---------------------------------------------------------------
   always_comb begin
      n          = s;
      core_we_w  = 1'b0;
      core_we_f  = 1'b0;
      pc_load_br = 1'b0;
      rd         = 32'h0000_0000;
      // Stopping only at a cycle boundary keeps Q phases whole
      cyc_go     = s.run || s.q != Q_DEC;
      setup      = PSEL && !PENABLE;
      wr_acc     = PSEL && PENABLE && s.pready && PWRITE;

      if (cyc_go) begin
         n.q = s.q + 2'h1;
      end

      if (cyc_go && s.st == ST_EXEC) begin
         case (s.q)
            Q_DEC:  n.ir   = PM_DATA;
            Q_RD:   n.opnd = s.files[fidx(s.ir)];
            Q_PROC: n.res  = a.res;
            Q_WR: begin
               core_we_w = a.we_w;
               core_we_f = a.we_f;
               if (core_we_w) begin
                  n.w = s.res;
               end
               if (core_we_f) begin
                  n.files[fidx(s.ir)] = s.res;
               end
               if (a.upd_z) begin
                  n.z = s.res == 8'h00;
               end
               if (a.is_br) begin
                  pc_load_br = 1'b1;
                  n.pc = {s.latch[LATCH_HI:LATCH_LO], s.ir[10:0]};
                  n.st = ST_FLUSH;
               end else begin
                  n.pc = s.pc + 13'h0001;
                  if (a.is_skz && s.res == 8'h00) begin
                     // Discarded word is stepped over at the flush end
                     n.st       = ST_FLUSH;
                     n.skip_inc = 1'b1;
                  end
               end
            end
            default: ;
         endcase
      end else if (cyc_go && s.st == ST_FLUSH && s.q == Q_WR) begin
         // Whole cycle idle; only the skip step of the PC remains
         n.st       = ST_EXEC;
         n.skip_inc = 1'b0;
         if (s.skip_inc) begin
            n.pc = s.pc + 13'h0001;
         end
      end

      // APB: answer is prepared in setup, presented in access
      rd[STAT_Z_BIT]                  = s.z;
      rd[STAT_FLUSH_BIT]              = s.st == ST_FLUSH;
      rd[STAT_Q_LSB+1:STAT_Q_LSB]     = s.q;
      case (PADDR)
         OFS_CTRL:  rd = {31'h0000_0000, s.run};
         OFS_WREG:  rd = {24'h00_0000, s.w};
         OFS_LATCH: rd = {27'h000_0000, s.latch};
         OFS_STAT:  ;
         OFS_PC:    rd = {19'h0_0000, s.pc};
         default: begin
            rd = 32'h0000_0000;
            if (file_hit(PADDR)) begin
               rd[7:0] = s.files[apb_idx(PADDR)];
            end
         end
      endcase

      n.pready  = setup;
      n.pslverr = 1'b0;
      if (setup) begin
         n.pslverr = !(PADDR == OFS_CTRL || PADDR == OFS_WREG ||
                       PADDR == OFS_LATCH || PADDR == OFS_STAT ||
                       PADDR == OFS_PC || file_hit(PADDR));
         n.prdata  = n.pslverr ? 32'h0000_0000 : rd;
      end

      // Software writes land last, so they win over the core
      if (wr_acc) begin
         case (PADDR)
            OFS_CTRL:  n.run   = PWDATA[CTRL_RUN_BIT];
            OFS_WREG:  n.w     = PWDATA[7:0];
            OFS_LATCH: n.latch = PWDATA[4:0];
            OFS_PC:    n.pc    = PWDATA[12:0];
            default: begin
               if (file_hit(PADDR)) begin
                  n.files[apb_idx(PADDR)] = PWDATA[7:0];
               end
            end
         endcase
      end
   end

   always_ff @(posedge REF_CLK) begin
      if (!RESET_N) begin
         s <= RST;
      end else begin
         s <= n;
      end
   end

   assign PRDATA  = s.prdata;
   assign PREADY  = s.pready;
   assign PSLVERR = s.pslverr;
   assign PM_ADDR = s.pc;

   // ---------------------------------------------------------------
   // Assertions
   // ---------------------------------------------------------------
   default clocking cb @(posedge REF_CLK); endclocking
   default disable iff (!RESET_N);

   logic       file_op;
   logic [3:0] op;

   assign file_op = s.ir[13:12] == CLS_FILE;
   assign op      = s.ir[11:8];

   sequence s_wr_phase;
      s.st == ST_EXEC && s.q == Q_WR;
   endsequence

   sequence s_proc_phase;
      s.st == ST_EXEC && s.q == Q_PROC;
   endsequence

   sequence s_flush_cycle;
      s.st == ST_FLUSH [*4];
   endsequence

   AST_DEST_W: assert property (s_wr_phase and file_op && op == OP_INC
      && !s.ir[IR_DEST_BIT] |-> core_we_w && !core_we_f)
      else $error("Destination 0 did not select W");

   AST_DEST_F: assert property (s_wr_phase and file_op && op == OP_DEC
      && s.ir[IR_DEST_BIT] && !wr_acc |=> s.files[fidx($past(s.ir))] == $past(s.res))
      else $error("Destination 1 did not write the file register");

   AST_COMP: assert property (s_proc_phase and file_op && op == OP_COMP
      |=> s.res == ~$past(s.opnd) ##1 !wr_acc ##0 1'b1 ##1 s.z == (s.res == 8'h00))
      else $error("Complement result or zero flag wrong");

   AST_DEC: assert property (s_proc_phase and file_op && op == OP_DEC
      |=> s.res == $past(s.opnd) - 8'h01 ##2 s.z == (s.res == 8'h00))
      else $error("Decrement result or zero flag wrong");

   AST_BR_PC: assert property (s_wr_phase and a.is_br && !wr_acc
      |=> s.pc == {$past(s.latch[LATCH_HI:LATCH_LO]), $past(s.ir[10:0])})
      else $error("Branch target not loaded");

   AST_BR_NOP: assert property (s_wr_phase and a.is_br |=> s_flush_cycle)
      else $error("Branch second cycle missing");

   AST_FLUSH_QUIET: assert property (s.st == ST_FLUSH
      |-> !core_we_w && !core_we_f && !pc_load_br)
      else $error("Activity during an idle cycle");

   AST_BR_Q4: assert property (pc_load_br |-> s.q == Q_WR
      && $past(s.q, 3) == Q_DEC)
      else $error("Branch PC write outside Q4");

   AST_INC: assert property (s_proc_phase and file_op && op == OP_INC
      |=> s.res == 8'(($past(s.opnd) + 9'h001) & 9'h0FF))
      else $error("Increment result wrong");

   AST_SKIP: assert property (s_wr_phase and a.is_skz && s.res == 8'h00
      && s.run && !wr_acc |=> s.st == ST_FLUSH && s.pc == $past(s.pc) + 13'h0001)
      else $error("Zero result did not start a skip");

   AST_IOR: assert property (s.st == ST_EXEC && s.q == Q_RD
      && s.ir[13:12] == CLS_LIT && op == OP_ORLIT && !wr_acc ##1 !wr_acc ##1 !wr_acc
      |=> s.w == ($past(s.w, 3) | $past(s.ir[7:0], 3)))
      else $error("OR literal into W wrong");

   AST_WR_Q4: assert property (core_we_w || core_we_f |-> s.q == Q_WR)
      else $error("Destination written outside Q4");

   AST_IR_Q1: assert property (s.ir != $past(s.ir) |-> $past(s.q) == Q_DEC)
      else $error("Instruction latched outside Q1");

endmodule // exec_core

// ---- dv/prog_mem_model.sv ----
// Program memory model: eight loadable words, self-branch everywhere else.
// Assumes the core samples pm_data at its Q1 edge.
`timescale 1ns/100ps
module prog_mem_model (
   input  wire exec_pkg::pc_t pm_addr,  // Word address
   output exec_pkg::instr_t   pm_data   // Instruction word
);
   import exec_pkg::*;
   instr_t mem [0:7];

   // ----------------------------------------------------------
   // Fetch
   // ----------------------------------------------------------
   // Unloaded words branch to themselves, so a stray fetch parks the core
   initial begin
      for (int i = 0; i < 8; i++) begin
         mem[i] = {CLS_BR, 1'h1, 11'(i)};
      end
   end

   always_comb begin
      pm_data = (pm_addr < 13'h0008) ? mem[pm_addr[2:0]] : {CLS_BR, 1'h1, pm_addr[10:0]};
   end
endmodule // prog_mem_model

// ---- dv/mcu_instruction_execute_subset_tb.sv ----
// Self-checking bench for the execute block: APB master and reference model.
// Assumes prog_mem_model as program memory and zero Z after reset.
`timescale 1ns/100ps
module mcu_instruction_execute_subset_tb;
   import exec_pkg::*;
   logic       REF_CLK, RESET_N, PSEL, PENABLE, PWRITE, PREADY, PSLVERR, err, mon;
   apb_addr_t  PADDR;
   word_t      PWDATA, PRDATA, rdat;
   pc_t        PM_ADDR, last_pc;
   instr_t     PM_DATA;
   int         fail_count, n_tests, zm, fl;
   int         cyc = 0;
   int         tq[$], aq[$];
   logic [3:0] opc [0:3] = '{OP_COMP, OP_DEC, OP_INC, OP_INCSZ};

   exec_core dut (.REF_CLK(REF_CLK), .RESET_N(RESET_N), .PSEL(PSEL), .PENABLE(PENABLE),
                  .PWRITE(PWRITE), .PADDR(PADDR), .PWDATA(PWDATA), .PRDATA(PRDATA),
                  .PREADY(PREADY), .PSLVERR(PSLVERR), .PM_ADDR(PM_ADDR), .PM_DATA(PM_DATA));
   prog_mem_model pm (.pm_addr(PM_ADDR), .pm_data(PM_DATA));

   // ----------------------------------------------------------
   // Clock and fetch trace
   // ----------------------------------------------------------
   initial begin
      REF_CLK = 1'h0;
      forever #10 REF_CLK = ~REF_CLK;
   end

   always @(posedge REF_CLK) begin
      cyc <= cyc + 1;
      if (mon && PM_ADDR !== last_pc) begin
         tq.push_back(cyc);
         aq.push_back(int'(PM_ADDR));
      end
      last_pc <= PM_ADDR;
   end

   // ----------------------------------------------------------
   // Tasks
   // ----------------------------------------------------------
   task automatic end_of_test;
      if (fail_count == 0 && n_tests > 0) $display("Result: passed");
      else $display("Result: failed");
      $finish;
   endtask

   task automatic chk(input string nm, input word_t exp, input word_t got);
      n_tests++;
      if (exp !== got) begin
         fail_count++;
         $display("BAD %s expected %h seen %h", nm, exp, got);
      end
   endtask

   // Entered just after a rising edge; leaves one idle cycle behind it
   task automatic apb(input logic wr, input apb_addr_t a, input word_t d);
      int n;
      PSEL <= 1'h1;
      PENABLE <= 1'h0;
      PWRITE <= wr;
      PADDR <= a;
      PWDATA <= d;
      @(posedge REF_CLK);
      PENABLE <= 1'h1;
      n = 0;
      do begin
         @(posedge REF_CLK);
         n++;
      end while (PREADY !== 1'h1 && n < 50);
      if (n >= 50) begin
         fail_count++;
         $display("BAD pready expected 1 seen %b", PREADY);
         end_of_test();
      end
      rdat = PRDATA;
      err = PSLVERR;
      PSEL <= 1'h0;
      PENABLE <= 1'h0;
      @(posedge REF_CLK);
   endtask

   task automatic run_op(input int sel, input logic bnd);
      logic [6:0]  f;
      logic        d;
      logic [7:0]  w0, f0, k, r;
      logic [10:0] kb;
      logic [4:0]  lat;
      apb_addr_t   fa;
      int          ew, ef, ez, epc;
      f = 7'($urandom);
      d = 1'($urandom);
      w0 = bnd ? 8'h00 : 8'($urandom);
      f0 = bnd ? ((sel == 1) ? 8'h01 : 8'hFF) : 8'($urandom);
      k = bnd ? 8'h00 : 8'($urandom);
      kb = 11'($urandom);
      lat = 5'($urandom);
      fa = OFS_FILE + 12'({f[3:0], 2'h0});
      case (sel)
         0: r = ~f0;
         1: r = f0 - 8'h01;
         4: r = w0 | k;
         default: r = f0 + 8'h01;
      endcase
      ew = w0;
      ef = f0;
      ez = zm;
      epc = (sel == 3 && r == 8'h00) ? 2 : 1;
      if (sel < 4 && d) ef = r;
      if (sel == 4 || (sel < 4 && !d)) ew = r;
      if (sel < 3 || sel == 4) ez = (r == 8'h00);
      // Idle words branch to themselves, so the latch bits reach the PC
      epc = (sel == 5) ? int'({lat[4:3], kb}) : int'({lat[4:3], 11'(epc)});
      // Five whole cycles per run; a branch in the last one parks the core idle
      fl = fl ^ int'(sel == 5 || (sel == 3 && r == 8'h00));
      zm = ez;
      pm.mem[0] = (sel == 4) ? {CLS_LIT, OP_ORLIT, k}
                : (sel == 5) ? {CLS_BR, 1'h1, kb} : {CLS_FILE, opc[sel[1:0]], d, f};
      apb(1'h1, OFS_WREG, 32'(w0));
      apb(1'h1, fa, 32'(f0));
      apb(1'h1, OFS_LATCH, 32'(lat));
      apb(1'h1, OFS_PC, 32'h0000_0000);
      apb(1'h1, OFS_CTRL, 32'h0000_0001);
      repeat (16) @(posedge REF_CLK);
      apb(1'h1, OFS_CTRL, 32'h0000_0000);
      repeat (12) @(posedge REF_CLK);
      apb(1'h0, OFS_WREG, 32'h0000_0000);
      chk("w", 32'(ew), rdat);
      apb(1'h0, fa, 32'h0000_0000);
      chk("file", 32'(ef), rdat);
      apb(1'h0, OFS_STAT, 32'h0000_0000);
      chk("status", 32'(ez) | (32'(fl) << STAT_FLUSH_BIT), rdat);
      apb(1'h0, OFS_PC, 32'h0000_0000);
      chk("pc", 32'(epc), rdat);
   endtask

   // ----------------------------------------------------------
   // Main sequence
   // ----------------------------------------------------------
   initial begin
      int ea[4] = '{1, 5, 6, 7};
      int ed[3] = '{4, 8, 4};
      RESET_N = 1'h0;
      PSEL = 1'h0;
      PENABLE = 1'h0;
      PWRITE = 1'h0;
      PADDR = '0;
      PWDATA = '0;
      mon = 1'h0;
      last_pc = '0;
      fail_count = 0;
      n_tests = 0;
      zm = 0;
      fl = 0;
      void'($urandom(47));
      repeat (6) @(posedge REF_CLK);
      RESET_N <= 1'h1;
      @(posedge REF_CLK);
      apb(1'h0, OFS_CTRL, 32'h0000_0000);
      chk("ctrl_rst", 32'(CTRL_RST), rdat);
      apb(1'h0, OFS_WREG, 32'h0000_0000);
      chk("w_rst", 32'(W_RST), rdat);
      apb(1'h0, OFS_LATCH, 32'h0000_0000);
      chk("latch_rst", 32'(LATCH_RST), rdat);
      apb(1'h0, OFS_PC, 32'h0000_0000);
      chk("pc_rst", 32'(PC_RST), rdat);
      // First free address past the file registers
      apb(1'h0, OFS_FILE + 12'h040, 32'h0000_0000);
      chk("slverr", 32'h0000_0001, 32'(err));
      chk("rdata_unmapped", 32'h0000_0000, rdat);
      for (int r = 0; r < 8; r++) begin
         for (int s = 0; s < 6; s++) begin
            run_op(s, r == 0);
         end
      end
      // Mid-run reset clears a parked idle cycle before the fixed program
      RESET_N <= 1'h0;
      repeat (2) @(posedge REF_CLK);
      RESET_N <= 1'h1;
      @(posedge REF_CLK);
      apb(1'h0, OFS_STAT, 32'h0000_0000);
      chk("stat_rst", 32'h0000_0000, rdat);
      // Increment, branch, skip taken: the word after the skip must not run
      pm.mem[0] = {CLS_FILE, OP_INC, 1'h1, 7'h03};
      pm.mem[1] = {CLS_BR, 1'h1, 11'h005};
      pm.mem[5] = {CLS_FILE, OP_INCSZ, 1'h1, 7'h04};
      pm.mem[6] = {CLS_FILE, OP_INC, 1'h1, 7'h03};
      apb(1'h1, OFS_FILE + 12'h00C, 32'h0000_0041);
      apb(1'h1, OFS_FILE + 12'h010, 32'h0000_00FF);
      apb(1'h1, OFS_LATCH, 32'h0000_0000);
      apb(1'h1, OFS_PC, 32'h0000_0000);
      mon = 1'h1;
      apb(1'h1, OFS_CTRL, 32'h0000_0001);
      repeat (24) @(posedge REF_CLK);
      apb(1'h1, OFS_CTRL, 32'h0000_0000);
      mon = 1'h0;
      repeat (12) @(posedge REF_CLK);
      chk("fetch_count", 32'h0000_0004, 32'(aq.size()));
      for (int i = 0; i < 4; i++) chk("pm_addr", 32'(ea[i]), 32'(aq[i]));
      for (int i = 0; i < 3; i++) chk("spacing", 32'(ed[i]), 32'(tq[i+1] - tq[i]));
      apb(1'h0, OFS_FILE + 12'h00C, 32'h0000_0000);
      chk("file3", 32'h0000_0042, rdat);
      apb(1'h0, OFS_FILE + 12'h010, 32'h0000_0000);
      chk("file4", 32'h0000_0000, rdat);
      end_of_test();
   end
endmodule // mcu_instruction_execute_subset_tb
